/* File: design/rtc_defs.svh */
// constants for the readout trigger control block
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH
// ----------------------------------------------------------------
// widths and depths
// ----------------------------------------------------------------
`define RTC_CH_N        4
`define RTC_DAT_W       12
`define RTC_COL_W       4
`define RTC_OUT_W       16
`define RTC_EVT_W       12
`define RTC_TB_DEPTH    3'h4
`define RTC_TB_PW       3
`define RTC_TB_IW       2
`define RTC_DB_W        3
`define RTC_DB_FULL     3'h4
// ----------------------------------------------------------------
// configuration registers, 4-bit index
// ----------------------------------------------------------------
`define RTC_REG_N       16
`define RTC_REG_CTRL    4'h0
`define RTC_REG_ADCCLK  4'h1
`define RTC_REG_LAT     4'h2
`define RTC_REG_STAT    4'h3
`define RTC_REG_EVT     4'h4
`define RTC_REG_REJ     4'h5
`define RTC_REG_BUNCH   4'h6
`define RTC_CFG_RST     8'h00
`define RTC_CTRL_FEINH  0
`define RTC_CTRL_TBINH  1
// ----------------------------------------------------------------
// packet layout
// ----------------------------------------------------------------
`define RTC_W_CTRL      3'h0
`define RTC_W_EVT       3'h1
`define RTC_W_SMP0      3'h2
`define RTC_W_LAST_FULL 3'h5
`define RTC_W_LAST_NULL 3'h1
`define RTC_CF_CAL      15
`define RTC_CF_NULL     14
// ----------------------------------------------------------------
// serial port
// ----------------------------------------------------------------
`define RTC_BITS_BYTE   4'h8
`endif

/* File: design/rtc_link_ch.sv */
// one adc channel: clock out and sample crossing into the system clock
`timescale 1ns/100ps
module rtc_link_ch
  import rtc_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     arst_n,
  input  wire logic     link_clk,
  input  wire logic     adc_clk_en,
  input  wire rtc_smp_t adc_in,
  output logic          adc_clk,
  output rtc_smp_t      smp,
  output logic          smp_stb
);
  // ----------------------------------------------------------------
  // link domain
  // ----------------------------------------------------------------
  logic     en_s1_reg, en_s2_reg, ack_s1_reg, ack_s2_reg, req_reg, adc_clk_reg;
  rtc_smp_t hold_reg;
  logic     ack_reg, req_s1_reg, req_s2_reg, req_s3_reg, stb_reg;
  rtc_smp_t smp_reg;

  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      en_s1_reg  <= 1'b0;
      en_s2_reg  <= 1'b0;
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
    end else begin
      en_s1_reg  <= adc_clk_en;
      en_s2_reg  <= en_s1_reg;
      ack_s1_reg <= ack_reg;
      ack_s2_reg <= ack_s1_reg;
    end
  end

  // each channel clock is enabled on its own
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) adc_clk_reg <= 1'b0;
    else adc_clk_reg <= en_s2_reg ? ~adc_clk_reg : 1'b0; // [R13]
  end

  // hold stays frozen until the system side acknowledges, so it needs no synchroniser
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_reg <= '0;
      req_reg  <= 1'b0;
    end else if (en_s2_reg && adc_clk_reg && (req_reg == ack_s2_reg)) begin
      hold_reg <= adc_in; // [R12]
      req_reg  <= ~req_reg;
    end
  end

  // ----------------------------------------------------------------
  // system domain
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      req_s1_reg <= 1'b0;
      req_s2_reg <= 1'b0;
      req_s3_reg <= 1'b0;
      ack_reg    <= 1'b0;
      smp_reg    <= '0;
      stb_reg    <= 1'b0;
    end else begin
      req_s1_reg <= req_reg;
      req_s2_reg <= req_s1_reg;
      req_s3_reg <= req_s2_reg;
      stb_reg    <= req_s2_reg ^ req_s3_reg;
      if (req_s2_reg ^ req_s3_reg) begin
        smp_reg <= hold_reg; // [R12]
        ack_reg <= req_s2_reg;
      end
    end
  end

  assign adc_clk = adc_clk_reg;
  assign smp     = smp_reg;
  assign smp_stb = stb_reg;
endmodule

/* File: design/rtc_pkg.sv */
// types shared by the readout trigger control block
package rtc_pkg;
  `include "rtc_defs.svh"

  typedef struct packed {
    logic [`RTC_COL_W-1:0] col;
    logic [`RTC_DAT_W-1:0] dat;
  } rtc_smp_t;

  typedef struct packed {
    logic                  l1;
    logic                  rsync;
    logic                  cal;
    logic [`RTC_CH_N-1:0]  afull;
    logic [`RTC_CH_N-1:0]  evtgl;
    logic [1:0]            addr;
    logic                  scl;
    logic                  sda;
  } rtc_pins_t;

  typedef struct packed {
    logic                  cal;
    logic                  nul;
    logic [`RTC_EVT_W-1:0] evt;
  } rtc_trig_t;

  typedef enum logic [2:0] {I2_IDLE, I2_ADDR, I2_AACK, I2_WR, I2_WACK, I2_RD, I2_RACK} rtc_i2_st_t;
  typedef enum logic {TX_IDLE, TX_SEND} rtc_tx_st_t;
endpackage

/* File: design/rtc_top.sv */
// readout trigger control: trigger filtering, packet output, serial configuration
// What this block does
// R1: front-end almost full, inhibit on: discard accept
// R2: discarded accept queues a flagged null event
// R3: data buffer never overflows; skipped events null
// R4: trigger buffer full, inhibit on: reject, flag
// R5: counters count every accept, rejected too
// R6: 16-bit words out, one strobe each
// R7: command_a always clears data and trigger buffers
// R8: calibration command fires accept after latency
// R9: calibration accept counts like external one
// R10: calibration packets carry calibration flag
// R11: packet control shows four front-end toggles
// R12: four channel buffers cross into system clock
// R13: four independently enabled adc clocks
// R14: serial lines synchronised before use
// R15: seven-bit address, low four pick register
// R16: next two bits match chip, top ignored
// R17: front-end toggles its flag per event
// R18: inhibit off: accept forwarded regardless
`timescale 1ns/100ps
module rtc_top
  import rtc_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic [`RTC_CH_N-1:0]  frontend_mux_clock,
  input  wire rtc_smp_t [`RTC_CH_N-1:0] adc_in,
  input  wire logic                  level1_accept_in,
  input  wire logic                  command_a,
  input  wire logic                  calibration_pulse_command,
  input  wire logic [`RTC_CH_N-1:0]  frontend_almost_full,
  input  wire logic [`RTC_CH_N-1:0]  frontend_event_toggle,
  input  wire logic [1:0]            chip_addr,
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe_n,
  output logic                       level1_accept,
  output logic [`RTC_CH_N-1:0]       adc_clk,
  output logic [`RTC_OUT_W-1:0]      out_data,
  output logic                       out_strobe
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  rtc_pins_t pin_s1_reg, pin_s2_reg, pin_d_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_d_reg  <= '0;
    end else begin
      pin_s1_reg <= {level1_accept_in, command_a, calibration_pulse_command, frontend_almost_full,
                     frontend_event_toggle, chip_addr, scl_in, sda_in}; // [R14]
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg  <= pin_s2_reg;
    end
  end
  logic l1_rise, rsync, cal_rise;
  assign l1_rise  = pin_s2_reg.l1 & ~pin_d_reg.l1;
  assign rsync    = pin_s2_reg.rsync & ~pin_d_reg.rsync;
  assign cal_rise = pin_s2_reg.cal & ~pin_d_reg.cal;

  // ----------------------------------------------------------------
  // adc channels
  // ----------------------------------------------------------------
  logic [7:0] cfg_reg [0:`RTC_REG_N-1];
  rtc_smp_t [`RTC_CH_N-1:0] smp;
  for (genvar g = 0; g < `RTC_CH_N; g++) begin : g_ch
    rtc_link_ch u_ch (
      .clk        (clk),
      .arst_n     (arst_n),
      .link_clk   (frontend_mux_clock[g]),
      .adc_clk_en (cfg_reg[`RTC_REG_ADCCLK][g]),
      .adc_in     (adc_in[g]),
      .adc_clk    (adc_clk[g]),
      .smp        (smp[g]),
      .smp_stb    ()
    );
  end

  // ----------------------------------------------------------------
  // trigger filter and counters
  // ----------------------------------------------------------------
  rtc_trig_t             tb_mem [0:`RTC_TB_DEPTH-1];
  logic [`RTC_TB_PW-1:0] tb_wp_reg, tb_rp_reg;
  logic [`RTC_DB_W-1:0]  db_cnt_reg;
  logic [`RTC_EVT_W-1:0] evt_cnt_reg, bunch_cnt_reg;
  logic [7:0]            rej_cnt_reg, lat_cnt_reg;
  logic                  rej_flag_reg, lost_flag_reg, cal_busy_reg, level1_reg;
  logic                  fe_inh_en, tb_inh_en, tb_full, tb_empty, db_full, fe_blk, tb_blk;
  logic                  cal_fire, l1_any, push, push_nul, pop, pkt_done, ctrl_sent;
  rtc_trig_t             cur_reg;

  assign fe_inh_en = cfg_reg[`RTC_REG_CTRL][`RTC_CTRL_FEINH];
  assign tb_inh_en = cfg_reg[`RTC_REG_CTRL][`RTC_CTRL_TBINH];
  assign tb_full   = (tb_wp_reg - tb_rp_reg) == `RTC_TB_DEPTH;
  assign tb_empty  = tb_wp_reg == tb_rp_reg;
  assign db_full   = db_cnt_reg == `RTC_DB_FULL;
  assign fe_blk    = fe_inh_en & (|pin_s2_reg.afull); // [R1] [R18]
  assign tb_blk    = tb_inh_en & tb_full; // [R4] [R18]
  assign cal_fire  = cal_busy_reg & (lat_cnt_reg == 8'h00) & ~l1_rise; // [R8]
  assign l1_any    = l1_rise | cal_fire; // [R9]
  // with trigger inhibit off a full buffer still forwards the accept; its entry is lost and flagged
  assign push      = l1_any & ~tb_full & ~rsync;
  assign push_nul  = fe_blk | db_full; // [R2] [R3]

  // calibration latency counts from the command; an external accept in the same cycle goes first
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cal_busy_reg <= 1'b0;
      lat_cnt_reg  <= 8'h00;
    end else if (cal_rise && !cal_busy_reg) begin
      cal_busy_reg <= 1'b1; // [R8]
      lat_cnt_reg  <= cfg_reg[`RTC_REG_LAT];
    end else if (cal_fire) begin
      cal_busy_reg <= 1'b0;
    end else if (cal_busy_reg && lat_cnt_reg != 8'h00) begin
      lat_cnt_reg <= lat_cnt_reg - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      evt_cnt_reg   <= '0;
      bunch_cnt_reg <= '0;
    end else if (l1_any) begin
      evt_cnt_reg   <= evt_cnt_reg + 1'b1; // [R5] [R9]
      bunch_cnt_reg <= bunch_cnt_reg + 1'b1; // [R5]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) level1_reg <= 1'b0;
    else level1_reg <= l1_any & ~tb_blk & ~fe_blk; // [R1] [R4] [R8] [R18]
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) rej_cnt_reg <= 8'h00;
    else if (l1_any && tb_blk) rej_cnt_reg <= rej_cnt_reg + 8'h01; // [R4]
  end

  // flags clear as a control word leaves; a new event in that cycle wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rej_flag_reg  <= 1'b0;
      lost_flag_reg <= 1'b0;
    end else begin
      rej_flag_reg  <= (l1_any & tb_blk) | (rej_flag_reg & ~ctrl_sent); // [R4]
      lost_flag_reg <= (l1_any & tb_full & ~tb_inh_en) | (lost_flag_reg & ~ctrl_sent);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) tb_wp_reg <= '0;
    else if (rsync) tb_wp_reg <= '0; // [R7]
    else if (push) tb_wp_reg <= tb_wp_reg + 1'b1;
  end

  always_ff @(posedge clk) begin
    if (push) tb_mem[tb_wp_reg[`RTC_TB_IW-1:0]] <= '{cal: cal_fire, nul: push_nul, evt: evt_cnt_reg}; // [R2] [R3]
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) tb_rp_reg <= '0;
    else if (rsync) tb_rp_reg <= '0; // [R7]
    else if (pop) tb_rp_reg <= tb_rp_reg + 1'b1;
  end

  // data buffer occupancy counts non-null events held until their packet is out
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) db_cnt_reg <= '0;
    else if (rsync) db_cnt_reg <= '0; // [R7]
    else db_cnt_reg <= db_cnt_reg + {2'h0, push & ~push_nul} - {2'h0, pkt_done & ~cur_reg.nul}; // [R3]
  end

  // ----------------------------------------------------------------
  // packet output
  // ----------------------------------------------------------------
  rtc_tx_st_t            tx_st_reg;
  logic [2:0]            widx_reg;
  logic [`RTC_OUT_W-1:0] out_data_reg;
  logic                  out_strobe_reg;

  function automatic logic [`RTC_OUT_W-1:0] pkt_word(input logic [2:0] idx);
    logic [2:0] ch;
    ch = idx - `RTC_W_SMP0;
    case (idx)
      `RTC_W_CTRL: pkt_word = {cur_reg.cal, cur_reg.nul, rej_flag_reg, lost_flag_reg,
                               pin_s2_reg.evtgl, 8'h00}; // [R10] [R11]
      `RTC_W_EVT:  pkt_word = {4'h0, cur_reg.evt};
      default:     pkt_word = smp[ch[1:0]];
    endcase
  endfunction

  assign pop       = (tx_st_reg == TX_IDLE) & ~tb_empty & ~rsync;
  assign pkt_done  = (tx_st_reg == TX_SEND) &
                     (widx_reg == (cur_reg.nul ? `RTC_W_LAST_NULL : `RTC_W_LAST_FULL));
  assign ctrl_sent = (tx_st_reg == TX_SEND) & (widx_reg == `RTC_W_CTRL);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_st_reg <= TX_IDLE;
      widx_reg  <= `RTC_W_CTRL;
      cur_reg   <= '0;
    end else if (rsync) begin
      tx_st_reg <= TX_IDLE; // [R7]
    end else begin
      case (tx_st_reg)
        TX_IDLE: if (pop) begin
          cur_reg   <= tb_mem[tb_rp_reg[`RTC_TB_IW-1:0]];
          widx_reg  <= `RTC_W_CTRL;
          tx_st_reg <= TX_SEND;
        end
        TX_SEND: begin
          widx_reg <= widx_reg + 3'h1;
          if (pkt_done) tx_st_reg <= TX_IDLE;
        end
        default: tx_st_reg <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_data_reg   <= '0;
      out_strobe_reg <= 1'b0;
    end else begin
      out_strobe_reg <= (tx_st_reg == TX_SEND) & ~rsync; // [R6]
      if (tx_st_reg == TX_SEND) out_data_reg <= pkt_word(widx_reg); // [R6]
    end
  end

  // ----------------------------------------------------------------
  // serial configuration port
  // ----------------------------------------------------------------
  rtc_i2_st_t i2_st_reg;
  logic [3:0] bcnt_reg, idx_reg;
  logic [7:0] sh_reg, rd_val;
  logic       rw_reg, oe_n_reg, scl, sda, i2_start, i2_stop, scl_rise, scl_fall, wr_stb;
  assign scl      = pin_s2_reg.scl;
  assign sda      = pin_s2_reg.sda;
  assign i2_start = scl & pin_d_reg.scl & pin_d_reg.sda & ~sda;
  assign i2_stop  = scl & pin_d_reg.scl & ~pin_d_reg.sda & sda;
  assign scl_rise = scl & ~pin_d_reg.scl;
  assign scl_fall = ~scl & pin_d_reg.scl;
  assign wr_stb   = (i2_st_reg == I2_WR) & scl_fall & (bcnt_reg == `RTC_BITS_BYTE);

  always_comb begin
    case (idx_reg)
      `RTC_REG_STAT:  rd_val = {pin_s2_reg.evtgl, |pin_s2_reg.afull, tb_full, db_full, rej_flag_reg};
      `RTC_REG_EVT:   rd_val = evt_cnt_reg[7:0];
      `RTC_REG_REJ:   rd_val = rej_cnt_reg;
      `RTC_REG_BUNCH: rd_val = bunch_cnt_reg[7:0];
      default:        rd_val = cfg_reg[idx_reg];
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `RTC_REG_N; i++) cfg_reg[i] <= `RTC_CFG_RST;
    end else if (wr_stb) begin
      cfg_reg[idx_reg] <= sh_reg; // [R15]
    end
  end

  // open drain: only ever pulls low, so the data output is tied to zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      i2_st_reg <= I2_IDLE;
      bcnt_reg  <= 4'h0;
      sh_reg    <= 8'h00;
      idx_reg   <= 4'h0;
      rw_reg    <= 1'b0;
      oe_n_reg  <= 1'b1;
    end else if (i2_start) begin
      i2_st_reg <= I2_ADDR;
      bcnt_reg  <= 4'h0;
      oe_n_reg  <= 1'b1;
    end else if (i2_stop) begin
      i2_st_reg <= I2_IDLE;
      oe_n_reg  <= 1'b1;
    end else begin
      case (i2_st_reg)
        I2_ADDR, I2_WR: if (scl_rise) begin
          sh_reg   <= {sh_reg[6:0], sda};
          bcnt_reg <= bcnt_reg + 4'h1;
        end else if (scl_fall && bcnt_reg == `RTC_BITS_BYTE) begin
          if (i2_st_reg == I2_WR) begin
            oe_n_reg  <= 1'b0;
            i2_st_reg <= I2_WACK;
          end else if (sh_reg[6:5] == pin_s2_reg.addr) begin // [R16]
            idx_reg   <= sh_reg[4:1]; // [R15]
            rw_reg    <= sh_reg[0];
            oe_n_reg  <= 1'b0;
            i2_st_reg <= I2_AACK;
          end else begin
            i2_st_reg <= I2_IDLE;
          end
        end
        I2_AACK, I2_WACK: if (scl_fall) begin
          bcnt_reg <= 4'h0;
          if (i2_st_reg == I2_AACK && rw_reg) begin
            sh_reg    <= rd_val;
            oe_n_reg  <= rd_val[7];
            i2_st_reg <= I2_RD;
          end else begin
            oe_n_reg  <= 1'b1;
            i2_st_reg <= I2_WR;
          end
        end
        I2_RD: if (scl_rise) begin
          bcnt_reg <= bcnt_reg + 4'h1;
        end else if (scl_fall) begin
          if (bcnt_reg == `RTC_BITS_BYTE) begin
            oe_n_reg  <= 1'b1;
            i2_st_reg <= I2_RACK;
          end else begin
            sh_reg   <= {sh_reg[6:0], 1'b0};
            oe_n_reg <= sh_reg[6];
          end
        end
        I2_RACK: if (scl_rise && sda) begin
          i2_st_reg <= I2_IDLE;
        end else if (scl_fall) begin
          bcnt_reg  <= 4'h0;
          sh_reg    <= rd_val;
          oe_n_reg  <= rd_val[7];
          i2_st_reg <= I2_RD;
        end
        default: i2_st_reg <= I2_IDLE;
      endcase
    end
  end

  assign sda_out       = 1'b0 & oe_n_reg;
  assign sda_oe_n      = oe_n_reg;
  assign level1_accept = level1_reg;
  assign out_data      = out_data_reg;
  assign out_strobe    = out_strobe_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_command_a_clear: assert property (rsync |=> tb_empty && db_cnt_reg == '0 && !out_strobe) // [R7]
    else $error("command_a left buffers occupied");
  a_fe_discard: assert property (l1_any && fe_blk |=> !level1_accept) // [R1]
    else $error("accept forwarded during front-end almost full");
  a_null_queued: assert property (l1_rise && fe_blk && !tb_full && !rsync |=> tb_wp_reg == $past(tb_wp_reg) + 3'h1)
    else $error("discarded accept queued no null event"); // [R2]
  a_db_bound: assert property (db_cnt_reg <= `RTC_DB_FULL) // [R3]
    else $error("data buffer overflow");
  a_tb_reject: assert property (l1_any && tb_blk |=> !level1_accept && rej_cnt_reg == $past(rej_cnt_reg) + 8'h01)
    else $error("full trigger buffer accept not rejected"); // [R4]
  a_evt_count: assert property (l1_any |=> evt_cnt_reg == $past(evt_cnt_reg) + 1'b1) // [R5]
    else $error("event counter missed an accept");
  a_no_inhibit: assert property (l1_any && !fe_inh_en && !tb_inh_en |=> level1_accept) // [R18]
    else $error("accept held back with inhibits off");
  a_cal_accept: assert property (cal_fire && !fe_blk && !tb_blk |=> level1_accept) // [R8]
    else $error("calibration accept not issued");
  a_packet_words: assert property ($rose(out_strobe) && !rsync |-> out_strobe[*2]) // [R6]
    else $error("packet shorter than two words");
  a_cal_flag: assert property (ctrl_sent && cur_reg.cal && !rsync |=> out_data[`RTC_CF_CAL]) // [R10]
    else $error("calibration flag missing");
  a_addr_miss: assert property (i2_st_reg == I2_ADDR && scl_fall && bcnt_reg == `RTC_BITS_BYTE && !i2_start
                                && !i2_stop && sh_reg[6:5] != pin_s2_reg.addr |=> sda_oe_n) // [R16]
    else $error("acknowledged a foreign address");

  c_command_a: cover property (rsync && !tb_empty);
  c_cal_pkt: cover property (ctrl_sent && cur_reg.cal);
  c_cfg_write: cover property (wr_stb);
  c_null_pkt: cover property (ctrl_sent && cur_reg.nul);
endmodule

/* File: test/rtc_fe_model.sv */
// model of the four front-end chips and their adcs
`timescale 1ns/100ps
module rtc_fe_model
  import rtc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              level1_accept,
  output logic [`RTC_CH_N-1:0]   frontend_mux_clock,
  output rtc_smp_t [`RTC_CH_N-1:0] adc_in,
  output logic [`RTC_CH_N-1:0]   frontend_event_toggle
);
  // ----
  // link clocks free-run, phase unrelated to clk
  // ----
  initial begin
    frontend_mux_clock = '0;
    #7;
    forever #32 frontend_mux_clock = ~frontend_mux_clock;
  end
  // fixed sample per channel so a swapped channel shows
  always_comb begin
    for (int g = 0; g < `RTC_CH_N; g++) begin
      adc_in[g] = {4'(g), 12'h5A0 | 12'(g)};
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      frontend_event_toggle <= '0;
    else if (level1_accept)
      frontend_event_toggle <= ~frontend_event_toggle;
  end
endmodule

/* File: test/tb_top.sv */
// self-checking bench for the readout trigger control block
`timescale 1ns/100ps
module tb_top
  import rtc_pkg::*;
;
  typedef struct packed {
    logic [7:0] cfg;
    logic [3:0] af;
    logic       cal;
    logic       nul;
    logic [3:0] nw;
  } rtc_row_t;
  logic           clk;
  logic           arst_n;
  logic           l1_pin;
  logic           rsync_pin;
  logic           cal_pin;
  logic           scl;
  logic           sda_drv;
  logic           sda_out;
  logic           sda_oe_n;
  logic           level1_accept;
  logic           out_strobe;
  logic           ack;
  logic [3:0]     afull;
  logic [3:0]     mux_clk;
  logic [3:0]     tgl;
  logic [3:0]     adc_clk;
  logic [15:0]    out_data;
  logic [15:0]    words [8];
  rtc_smp_t [3:0] adc_in;
  logic [11:0]    evt0;
  int             mismatches;
  int             total_checks;
  int             cycles;
  int             l1_cnt;
  int             c0;
  int             nw;
  wire            sda_w = sda_drv & (sda_oe_n | sda_out);
  rtc_row_t       rows [5] = '{'{8'h00, 4'h0, 1'b0, 1'b0, 4'h6}, '{8'h00, 4'hF, 1'b0, 1'b0, 4'h6},
                               '{8'h01, 4'h1, 1'b0, 1'b1, 4'h2}, '{8'h01, 4'h0, 1'b0, 1'b0, 4'h6},
                               '{8'h00, 4'h0, 1'b1, 1'b0, 4'h6}};
  rtc_top u_rtc_top (
    .clk                       (clk),
    .arst_n                    (arst_n),
    .frontend_mux_clock        (mux_clk),
    .adc_in                    (adc_in),
    .level1_accept_in          (l1_pin),
    .command_a                 (rsync_pin),
    .calibration_pulse_command (cal_pin),
    .frontend_almost_full      (afull),
    .frontend_event_toggle     (tgl),
    .chip_addr                 (2'b10),
    .scl_in                    (scl),
    .sda_in                    (sda_w),
    .sda_out                   (sda_out),
    .sda_oe_n                  (sda_oe_n),
    .level1_accept             (level1_accept),
    .adc_clk                   (adc_clk),
    .out_data                  (out_data),
    .out_strobe                (out_strobe)
  );
  rtc_fe_model u_rtc_fe_model (
    .clk                   (clk),
    .arst_n                (arst_n),
    .level1_accept         (level1_accept),
    .frontend_mux_clock    (mux_clk),
    .adc_in                (adc_in),
    .frontend_event_toggle (tgl)
  );
  // ----
  // helpers
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic w4;
    repeat (4) @(posedge clk);
  endtask
  task automatic sbit(input logic b);
    sda_drv <= b;
    w4();
    scl <= 1'b1;
    w4();
    ack = sda_w;
    scl <= 1'b0;
    w4();
  endtask
  // write one byte to a register; ack holds the address acknowledge
  task automatic i2c_wr(input logic [1:0] dev, input logic [3:0] idx, input logic [7:0] d);
    logic [7:0] a;
    logic       a_ack;
    a = {1'b1, dev, idx, 1'b0};
    sda_drv <= 1'b0;
    w4();
    scl <= 1'b0;
    w4();
    for (int k = 7; k >= 0; k--) sbit(a[k]);
    sbit(1'b1);
    a_ack = ack;
    for (int k = 7; k >= 0; k--) sbit(d[k]);
    sbit(1'b1);
    sda_drv <= 1'b0;
    w4();
    scl <= 1'b1;
    w4();
    sda_drv <= 1'b1;
    w4();
    ack = a_ack;
  endtask
  // fifo side: one word per strobe cycle
  task automatic get_pkt;
    int t;
    nw = 0;
    t = 0;
    while (out_strobe !== 1'b1 && t < 60) begin
      @(posedge clk);
      t++;
    end
    while (out_strobe === 1'b1 && nw < 8) begin
      words[nw] = out_data;
      nw++;
      @(posedge clk);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (level1_accept === 1'b1)
      l1_cnt++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    {arst_n, l1_pin, rsync_pin, cal_pin} = '0;
    {scl, sda_drv} = 2'b11;
    afull = 4'h0;
    repeat (16) @(posedge clk);
    chk({level1_accept, out_strobe, sda_oe_n, adc_clk}, 16'h0010);
    chk(out_data, 16'h0000);
    arst_n <= 1'b1;
    w4();
    i2c_wr(2'b10, 4'h1, 8'h0F);
    chk(ack, 1'b0);
    i2c_wr(2'b01, 4'h1, 8'h00);
    chk(ack, 1'b1);
    foreach (rows[i]) begin
      i2c_wr(2'b10, 4'h0, rows[i].cfg);
      afull <= rows[i].af;
      w4();
      c0 = l1_cnt;
      if (rows[i].cal)
        cal_pin <= 1'b1;
      else
        l1_pin <= 1'b1;
      repeat (3) @(posedge clk);
      {cal_pin, l1_pin} <= 2'b00;
      get_pkt();
      if (i == 0)
        evt0 = words[1][11:0];
      chk(16'(nw), rows[i].nw);
      // toggles reach the control word before this event's own flip has crossed the synchronisers
      chk(words[0][15:8], {rows[i].cal, rows[i].nul, 2'b00, {4{c0[0]}}});
      chk(words[1], {4'h0, evt0 + 12'(i)});
      chk(16'(l1_cnt - c0), {15'h0, ~rows[i].nul});
      for (int g = 0; g < 4 && !rows[i].nul; g++) chk(words[2+g], {4'(g), 12'h5A0 | 12'(g)});
    end
    // two queued accepts, command_a after the first packet: abort the second and flush
    afull <= 4'h0;
    fork
      repeat (2) begin
        l1_pin <= 1'b1;
        repeat (2) @(posedge clk);
        l1_pin <= 1'b0;
        repeat (2) @(posedge clk);
      end
    join_none
    get_pkt();
    rsync_pin <= 1'b1;
    repeat (3) @(posedge clk);
    rsync_pin <= 1'b0;
    repeat (2) @(posedge clk);
    chk(out_strobe, 1'b0);
    repeat (8) @(posedge clk);
    get_pkt();
    chk(16'(nw), 16'h0000);
    test_done();
  end
endmodule
